// ==== bench/brp_mem_model.sv ====
`timescale 1ns/1ps
module brp_mem_model
    import brp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        mem_valid,
    output logic             mem_ready,
    input  wire logic [31:0] mem_len,
    output logic             mem_done,
    output logic             mem_err,
    output logic [31:0]      mem_xfer_bytes,
    output logic [31:0]      mem_sense_bytes,
    input  wire logic        err_in,
    input  wire logic [31:0] short_in,
    input  wire logic [31:0] sense_in,
    input  wire logic [3:0]  lat
);
    logic [3:0] cnt_r;
    logic       wait_r;
    always @(posedge mclk) begin
        mem_ready       <= 1'b0;
        mem_done        <= 1'b0;
        mem_err         <= ~mem_err;
        mem_xfer_bytes  <= ~mem_xfer_bytes;
        mem_sense_bytes <= ~mem_sense_bytes;
        if (!resetn) begin
            {cnt_r, wait_r, mem_err, mem_xfer_bytes, mem_sense_bytes} <= '0;
        end else if (cnt_r < lat) begin
            cnt_r <= cnt_r + 4'h1;
        end else if (!wait_r && mem_valid && !mem_ready) begin
            mem_ready <= 1'b1;
            wait_r    <= 1'b1;
            cnt_r     <= 4'h0;
        end else if (wait_r) begin
            // done only once data moved or cache made durable
            mem_done        <= 1'b1;
            mem_err         <= err_in;
            mem_xfer_bytes  <= mem_len - short_in;
            mem_sense_bytes <= sense_in;
            wait_r          <= 1'b0;
            cnt_r           <= 4'h0;
        end
    end
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import brp_pkg::*;
    logic        mclk, resetn, feat_ro, feat_barrier, feat_scsi, legacy_mode, guest_big_endian;
    logic        req_valid, req_ready, mem_valid, mem_ready, mem_barrier, mem_done, mem_err;
    logic        cpl_valid, cpl_ready, busy, err_in;
    logic [63:0] capacity_sectors, req_sector_raw, mem_addr;
    logic [31:0] req_type_raw, req_prio_raw, req_data_bytes, req_cmd_bytes, mem_len;
    logic [31:0] mem_cmd_len, mem_prio, mem_xfer_bytes, mem_sense_bytes, cpl_used_len;
    logic [31:0] cpl_sense_len, cpl_residual, short_in, sense_in;
    logic [15:0] req_tag, cpl_tag;
    logic [7:0]  cpl_status;
    logic [3:0]  lat;
    brp_op_t     mem_op;
    int          error_cnt = 0;
    int          compares = 0;
    brp_request_proc i_dut (.*);
    brp_mem_model    i_mem (.*);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // eop 7: request must never reach the backend
    task automatic req(logic [31:0] ty, logic [63:0] sec, logic [31:0] dl, logic [2:0] eop,
                       logic [63:0] ea, logic [7:0] est, logic [31:0] eu);
        logic seen;
        seen = 1'b0;
        @(posedge mclk);
        req_type_raw   <= ty;
        req_sector_raw <= sec;
        req_data_bytes <= dl;
        req_tag        <= req_tag + 16'h1;
        req_valid      <= 1'b1;
        do @(posedge mclk); while (req_ready !== 1'b1);
        chk("busy", busy, 1'b0);
        req_valid <= 1'b0;
        for (int n = 0; n < 60 && cpl_valid !== 1'b1; n++) begin
            @(posedge mclk);
            if (mem_valid === 1'b1 && !seen) begin
                seen = 1'b1;
                chk("busy", busy, 1'b1);
                chk("mem_op", mem_op, eop);
                chk("mem_addr", mem_addr, ea);
                chk("mem_len", mem_len, eop == BRP_OP_FLUSH ? 0 : dl);
                chk("mem_barrier", mem_barrier, ty[31] & feat_barrier);
                chk("mem_prio", mem_prio, (legacy_mode && guest_big_endian) ?
                    {req_prio_raw[7:0], req_prio_raw[15:8], req_prio_raw[23:16],
                     req_prio_raw[31:24]} : req_prio_raw);
                if (eop == BRP_OP_SCSI) chk("mem_cmd_len", mem_cmd_len, req_cmd_bytes);
            end
        end
        chk("cpl_valid", cpl_valid, 1'b1);
        chk("backend used", seen, eop != 3'h7);
        chk("cpl_status", cpl_status, est);
        chk("cpl_tag", cpl_tag, req_tag);
        chk("cpl_used_len", cpl_used_len, eu);
        if (eop == BRP_OP_SCSI) begin
            chk("cpl_sense_len", cpl_sense_len, sense_in > 96 ? 96 : sense_in);
            chk("cpl_residual", cpl_residual, short_in);
        end
        cpl_ready <= 1'b1;
        @(posedge mclk);
        cpl_ready <= 1'b0;
    endtask
    initial begin
        {resetn, feat_ro, feat_barrier, feat_scsi, legacy_mode, guest_big_endian} = '0;
        {req_valid, cpl_ready, err_in, req_tag, req_type_raw, req_sector_raw} = '0;
        {req_data_bytes, short_in, sense_in} = '0;
        req_prio_raw     = 32'h7;
        req_cmd_bytes    = 32'hC;
        capacity_sectors = 64'h100;
        lat              = 4'h1;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        req(32'h0, 64'h3, 32'h400, BRP_OP_READ, 64'h600, STAT_OK, 32'h401);
        req(32'h1, 64'h2, 32'h200, BRP_OP_WRITE, 64'h400, STAT_OK, 32'h1);
        req(32'h4, 64'h0, 32'h0, BRP_OP_FLUSH, 64'h0, STAT_OK, 32'h1);
        for (int t = 2; t < 8; t++) if (t != 4) req(t, 64'h0, 32'h0, 3'h7, 64'h0, STAT_UNSUPP, 32'h1);
        req(32'h0, 64'hFF, 32'h200, BRP_OP_READ, 64'h1_FE00, STAT_OK, 32'h201);
        req(32'h0, 64'h100, 32'h200, 3'h7, 64'h0, STAT_IOERR, 32'h1);
        $display("test basic done");
        legacy_mode  <= 1'b1;
        feat_scsi    <= 1'b1;
        feat_barrier <= 1'b1;
        sense_in     <= 32'hC8;
        short_in     <= 32'h200;
        lat          <= 4'h5;
        req(32'h5, 64'h0, 32'h0, BRP_OP_FLUSH, 64'h0, STAT_OK, 32'h1);
        for (int t = 2; t < 4; t++) req(t, 64'h0, 32'h400, BRP_OP_SCSI, 64'h0, STAT_OK, 32'h271);
        short_in <= 32'h0;
        req(32'h8000_0000, 64'h1, 32'h200, BRP_OP_READ, 64'h200, STAT_OK, 32'h201);
        guest_big_endian <= 1'b1;
        req(32'h0100_0000, 64'h0400_0000_0000_0000, 32'h200, BRP_OP_WRITE, 64'h800, STAT_OK, 32'h1);
        $display("test legacy done");
        {guest_big_endian, legacy_mode} <= 2'b00;
        feat_ro <= 1'b1;
        req(32'h1, 64'h2, 32'h200, 3'h7, 64'h0, STAT_IOERR, 32'h1);
        feat_ro <= 1'b0;
        err_in  <= 1'b1;
        req(32'h0, 64'h2, 32'h200, BRP_OP_READ, 64'h400, STAT_IOERR, 32'h1);
        $display("test errors done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end
endmodule

// ==== src/brp_hdr_decode.sv ====
`timescale 1ns/1ps
module brp_hdr_decode
    import brp_pkg::*;
(
    input  wire logic        legacy_mode,
    input  wire logic        guest_big_endian,
    input  wire logic        feat_barrier,
    input  wire logic        feat_scsi,
    input  wire logic [31:0] type_raw,
    input  wire logic [31:0] prio_raw,
    input  wire logic [63:0] sector_raw,
    output brp_op_t          op,
    output logic             barrier,
    output logic [31:0]      prio,
    output logic [63:0]      sector
);

    // ----------------------------------------------------------------
    // byte order helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] swap32(input logic [31:0] v);
        swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    function automatic logic [63:0] swap64(input logic [63:0] v);
        swap64 = {swap32(v[31:0]), swap32(v[63:32])};
    endfunction

    // ----------------------------------------------------------------
    // field extraction and type decode
    // ----------------------------------------------------------------
    logic        swap;
    logic [31:0] type_val;
    logic [31:0] code;

    always_comb begin
        swap     = legacy_mode && guest_big_endian;
        type_val = swap ? swap32(type_raw) : type_raw;
        prio     = swap ? swap32(prio_raw) : prio_raw;
        sector   = swap ? swap64(sector_raw) : sector_raw;
        barrier  = feat_barrier && ((type_val & TYPE_BARRIER) != '0);
        code     = feat_barrier ? (type_val & ~TYPE_BARRIER) : type_val;
        if (code == TYPE_READ) begin
            op = BRP_OP_READ;
        end else if (code == TYPE_WRITE) begin
            op = BRP_OP_WRITE;
        end else if (code == TYPE_FLUSH) begin
            op = BRP_OP_FLUSH;
        end else if (legacy_mode && code == TYPE_FLUSH_LEG) begin
            op = BRP_OP_FLUSH;
        end else if (feat_scsi && (code == TYPE_SCSI_A || code == TYPE_SCSI_B)) begin
            op = BRP_OP_SCSI;
        end else begin
            op = BRP_OP_UNSUPP;
        end
    end

endmodule

// ==== src/brp_pkg.sv ====
// ----------------------------------------------------------------
// request layout and codes
// ----------------------------------------------------------------
package brp_pkg;

    localparam int unsigned SECTOR_SHIFT     = 9;
    localparam logic [31:0] SECTOR_MASK      = 32'h0000_01FF;

    localparam logic [31:0] TYPE_READ        = 32'h0000_0000;
    localparam logic [31:0] TYPE_WRITE       = 32'h0000_0001;
    localparam logic [31:0] TYPE_SCSI_A      = 32'h0000_0002;
    localparam logic [31:0] TYPE_SCSI_B      = 32'h0000_0003;
    localparam logic [31:0] TYPE_FLUSH       = 32'h0000_0004;
    localparam logic [31:0] TYPE_FLUSH_LEG   = 32'h0000_0005;
    localparam logic [31:0] TYPE_BARRIER     = 32'h8000_0000;

    localparam logic [7:0]  STAT_OK          = 8'h00;
    localparam logic [7:0]  STAT_IOERR       = 8'h01;
    localparam logic [7:0]  STAT_UNSUPP      = 8'h02;

    localparam logic [31:0] SENSE_BYTES      = 32'h0000_0060;
    localparam logic [31:0] SCSI_TRAIL_BYTES = 32'h0000_0010;
    localparam logic [31:0] STATUS_BYTES     = 32'h0000_0001;

    typedef enum logic [2:0] {
        BRP_OP_READ   = 3'h0,
        BRP_OP_WRITE  = 3'h1,
        BRP_OP_FLUSH  = 3'h2,
        BRP_OP_SCSI   = 3'h3,
        BRP_OP_UNSUPP = 3'h4
    } brp_op_t;

    typedef enum logic [2:0] {
        BRP_ST_IDLE  = 3'h0,
        BRP_ST_CHECK = 3'h1,
        BRP_ST_MEM   = 3'h2,
        BRP_ST_WAIT  = 3'h3,
        BRP_ST_CPL   = 3'h4
    } brp_state_t;

endpackage

// ==== src/brp_request_proc.sv ====
`timescale 1ns/1ps
module brp_request_proc
    import brp_pkg::*;
#(
    parameter int unsigned TAG_W = 16
)(
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             feat_ro,
    input  wire logic             feat_barrier,
    input  wire logic             feat_scsi,
    input  wire logic             legacy_mode,
    input  wire logic             guest_big_endian,
    input  wire logic [63:0]      capacity_sectors,
    input  wire logic             req_valid,
    output logic                  req_ready,
    input  wire logic [TAG_W-1:0] req_tag,
    input  wire logic [31:0]      req_type_raw,
    input  wire logic [31:0]      req_prio_raw,
    input  wire logic [63:0]      req_sector_raw,
    input  wire logic [31:0]      req_data_bytes,
    input  wire logic [31:0]      req_cmd_bytes,
    output logic                  mem_valid,
    input  wire logic             mem_ready,
    output brp_op_t               mem_op,
    output logic [63:0]           mem_addr,
    output logic [31:0]           mem_len,
    output logic [31:0]           mem_cmd_len,
    output logic [31:0]           mem_prio,
    output logic                  mem_barrier,
    input  wire logic             mem_done,
    input  wire logic             mem_err,
    input  wire logic [31:0]      mem_xfer_bytes,
    input  wire logic [31:0]      mem_sense_bytes,
    output logic                  cpl_valid,
    input  wire logic             cpl_ready,
    output logic [TAG_W-1:0]      cpl_tag,
    output logic [7:0]            cpl_status,
    output logic [31:0]           cpl_used_len,
    output logic [31:0]           cpl_sense_len,
    output logic [31:0]           cpl_residual,
    output logic                  busy
);

    // ----------------------------------------------------------------
    // header decode and pass-through results
    // ----------------------------------------------------------------
    brp_op_t     dec_op;
    logic        dec_barrier;
    logic [31:0] dec_prio;
    logic [63:0] dec_sector;
    logic [31:0] scsi_sense_len;
    logic [31:0] scsi_residual;

    brp_hdr_decode u_hdr (
        .legacy_mode      (legacy_mode),
        .guest_big_endian (guest_big_endian),
        .feat_barrier     (feat_barrier),
        .feat_scsi        (feat_scsi),
        .type_raw         (req_type_raw),
        .prio_raw         (req_prio_raw),
        .sector_raw       (req_sector_raw),
        .op               (dec_op),
        .barrier          (dec_barrier),
        .prio             (dec_prio),
        .sector           (dec_sector)
    );

    // ----------------------------------------------------------------
    // request state
    // ----------------------------------------------------------------
    brp_state_t       state_r,       state_nxt;
    logic             req_ready_r,   req_ready_nxt;
    logic [TAG_W-1:0] tag_r,         tag_nxt;
    brp_op_t          op_r,          op_nxt;
    logic             barrier_r,     barrier_nxt;
    logic [31:0]      prio_r,        prio_nxt;
    logic [63:0]      sector_r,      sector_nxt;
    logic [31:0]      dlen_r,        dlen_nxt;
    logic [31:0]      clen_r,        clen_nxt;
    logic             mem_valid_r,   mem_valid_nxt;
    logic [63:0]      mem_addr_r,    mem_addr_nxt;
    logic [31:0]      mem_len_r,     mem_len_nxt;
    logic             cpl_valid_r,   cpl_valid_nxt;
    logic [7:0]       cpl_status_r,  cpl_status_nxt;
    logic [31:0]      cpl_used_r,    cpl_used_nxt;
    logic [31:0]      cpl_sense_r,   cpl_sense_nxt;
    logic [31:0]      cpl_resid_r,   cpl_resid_nxt;
    logic             busy_r,        busy_nxt;
    logic [64:0]      end_sector;
    logic             bad_range;

    brp_scsi_result u_scsi (
        .data_bytes  (dlen_r),
        .xfer_bytes  (mem_xfer_bytes),
        .sense_bytes (mem_sense_bytes),
        .sense_len   (scsi_sense_len),
        .residual    (scsi_residual)
    );

    always_comb begin
        state_nxt      = state_r;
        req_ready_nxt  = req_ready_r;
        tag_nxt        = tag_r;
        op_nxt         = op_r;
        barrier_nxt    = barrier_r;
        prio_nxt       = prio_r;
        sector_nxt     = sector_r;
        dlen_nxt       = dlen_r;
        clen_nxt       = clen_r;
        mem_valid_nxt  = mem_valid_r;
        mem_addr_nxt   = mem_addr_r;
        mem_len_nxt    = mem_len_r;
        cpl_valid_nxt  = cpl_valid_r;
        cpl_status_nxt = cpl_status_r;
        cpl_used_nxt   = cpl_used_r;
        cpl_sense_nxt  = cpl_sense_r;
        cpl_resid_nxt  = cpl_resid_r;
        end_sector     = {1'b0, sector_r} + {33'b0, dlen_r >> SECTOR_SHIFT};
        bad_range      = ((dlen_r & SECTOR_MASK) != '0)
                      || (end_sector > {1'b0, capacity_sectors});
        case (state_r)
            BRP_ST_IDLE: begin
                if (req_valid && req_ready_r) begin
                    req_ready_nxt = 1'b0;   // one request in flight orders barriers
                    tag_nxt       = req_tag;
                    op_nxt        = dec_op;
                    barrier_nxt   = dec_barrier;
                    prio_nxt      = dec_prio;
                    sector_nxt    = dec_sector;
                    dlen_nxt      = req_data_bytes;
                    clen_nxt      = req_cmd_bytes;
                    state_nxt     = BRP_ST_CHECK;
                end else begin
                    req_ready_nxt = 1'b1;
                end
            end
            BRP_ST_CHECK: begin
                cpl_sense_nxt = '0;
                cpl_resid_nxt = '0;
                cpl_used_nxt  = STATUS_BYTES;
                if (op_r == BRP_OP_UNSUPP) begin
                    cpl_status_nxt = STAT_UNSUPP;
                    cpl_valid_nxt  = 1'b1;
                    state_nxt      = BRP_ST_CPL;
                end else if (op_r == BRP_OP_WRITE && feat_ro) begin
                    cpl_status_nxt = STAT_IOERR;
                    cpl_valid_nxt  = 1'b1;
                    state_nxt      = BRP_ST_CPL;
                end else if ((op_r == BRP_OP_READ || op_r == BRP_OP_WRITE) && bad_range) begin
                    cpl_status_nxt = STAT_IOERR;
                    cpl_valid_nxt  = 1'b1;
                    state_nxt      = BRP_ST_CPL;
                end else begin
                    mem_valid_nxt = 1'b1;
                    if (op_r == BRP_OP_READ || op_r == BRP_OP_WRITE) begin
                        mem_addr_nxt = sector_r << SECTOR_SHIFT;
                        mem_len_nxt  = dlen_r;
                    end else if (op_r == BRP_OP_SCSI) begin
                        mem_addr_nxt = '0;
                        mem_len_nxt  = dlen_r;
                    end else begin
                        mem_addr_nxt = '0;
                        mem_len_nxt  = '0;
                    end
                    state_nxt = BRP_ST_MEM;
                end
            end
            BRP_ST_MEM: begin
                if (mem_ready) begin
                    mem_valid_nxt = 1'b0;
                    state_nxt     = BRP_ST_WAIT;
                end
            end
            BRP_ST_WAIT: begin
                // backend done covers data and, for flush, durable commit
                if (mem_done) begin
                    cpl_status_nxt = mem_err ? STAT_IOERR : STAT_OK;
                    cpl_used_nxt   = STATUS_BYTES;
                    if (op_r == BRP_OP_SCSI) begin
                        cpl_sense_nxt = scsi_sense_len;
                        cpl_resid_nxt = scsi_residual;
                        cpl_used_nxt  = mem_xfer_bytes + SENSE_BYTES
                                      + SCSI_TRAIL_BYTES + STATUS_BYTES;
                    end else if (op_r == BRP_OP_READ && !mem_err) begin
                        cpl_used_nxt  = dlen_r + STATUS_BYTES;
                    end
                    cpl_valid_nxt = 1'b1;
                    state_nxt     = BRP_ST_CPL;
                end
            end
            BRP_ST_CPL: begin
                if (cpl_ready) begin
                    cpl_valid_nxt = 1'b0;
                    req_ready_nxt = 1'b1;
                    state_nxt     = BRP_ST_IDLE;
                end
            end
            default: begin
                state_nxt     = BRP_ST_IDLE;
                req_ready_nxt = 1'b1;
                mem_valid_nxt = 1'b0;
                cpl_valid_nxt = 1'b0;
            end
        endcase
        busy_nxt = !req_ready_nxt;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r      <= BRP_ST_IDLE;
            req_ready_r  <= 1'b0;
            tag_r        <= '0;
            op_r         <= BRP_OP_READ;
            barrier_r    <= 1'b0;
            prio_r       <= '0;
            sector_r     <= '0;
            dlen_r       <= '0;
            clen_r       <= '0;
            mem_valid_r  <= 1'b0;
            mem_addr_r   <= '0;
            mem_len_r    <= '0;
            cpl_valid_r  <= 1'b0;
            cpl_status_r <= STAT_OK;
            cpl_used_r   <= '0;
            cpl_sense_r  <= '0;
            cpl_resid_r  <= '0;
            busy_r       <= 1'b1;
        end else begin
            state_r      <= state_nxt;
            req_ready_r  <= req_ready_nxt;
            tag_r        <= tag_nxt;
            op_r         <= op_nxt;
            barrier_r    <= barrier_nxt;
            prio_r       <= prio_nxt;
            sector_r     <= sector_nxt;
            dlen_r       <= dlen_nxt;
            clen_r       <= clen_nxt;
            mem_valid_r  <= mem_valid_nxt;
            mem_addr_r   <= mem_addr_nxt;
            mem_len_r    <= mem_len_nxt;
            cpl_valid_r  <= cpl_valid_nxt;
            cpl_status_r <= cpl_status_nxt;
            cpl_used_r   <= cpl_used_nxt;
            cpl_sense_r  <= cpl_sense_nxt;
            cpl_resid_r  <= cpl_resid_nxt;
            busy_r       <= busy_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign req_ready     = req_ready_r;
    assign mem_valid     = mem_valid_r;
    assign mem_op        = op_r;
    assign mem_addr      = mem_addr_r;
    assign mem_len       = mem_len_r;
    assign mem_cmd_len   = clen_r;
    assign mem_prio      = prio_r;
    assign mem_barrier   = barrier_r;
    assign cpl_valid     = cpl_valid_r;
    assign cpl_tag       = tag_r;
    assign cpl_status    = cpl_status_r;
    assign cpl_used_len  = cpl_used_r;
    assign cpl_sense_len = cpl_sense_r;
    assign cpl_residual  = cpl_resid_r;
    assign busy          = busy_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_ro_write_fails: assert property (
        state_r == BRP_ST_CHECK && op_r == BRP_OP_WRITE && feat_ro
        |=> cpl_valid_r && cpl_status_r == STAT_IOERR && !mem_valid_r)
        else $error("read-only write not failed");
    a_unknown_unsupp: assert property (
        state_r == BRP_ST_CHECK && op_r == BRP_OP_UNSUPP
        |=> cpl_valid_r && cpl_status_r == STAT_UNSUPP && !mem_valid_r)
        else $error("unknown type not answered unsupported");
    a_addr_scaled: assert property (
        mem_valid_r && (op_r == BRP_OP_READ || op_r == BRP_OP_WRITE)
        |-> mem_addr_r == (sector_r << SECTOR_SHIFT) && mem_len_r == dlen_r)
        else $error("storage offset not sector times block size");
    a_flush_no_addr: assert property (
        mem_valid_r && (op_r == BRP_OP_FLUSH || op_r == BRP_OP_SCSI)
        |-> mem_addr_r == '0)
        else $error("sector used for flush or pass-through");
    a_cpl_after_done: assert property (
        $rose(cpl_valid_r) && $past(state_r) == BRP_ST_WAIT |-> $past(mem_done))
        else $error("completion before data done");
    a_done_to_status: assert property (
        state_r == BRP_ST_WAIT && mem_done
        |=> cpl_valid_r && cpl_status_r == ($past(mem_err) ? STAT_IOERR : STAT_OK))
        else $error("wrong status after backend done");
    a_one_in_flight: assert property (
        mem_valid_r || cpl_valid_r || state_r == BRP_ST_WAIT |-> !req_ready_r)
        else $error("new request accepted while one in flight");
    a_sense_clamped: assert property (
        cpl_valid_r |-> cpl_sense_r <= SENSE_BYTES)
        else $error("sense length above sense area");
    a_residual_calc: assert property (
        state_r == BRP_ST_WAIT && mem_done && op_r == BRP_OP_SCSI
        && mem_xfer_bytes <= dlen_r |=> cpl_resid_r == $past(dlen_r - mem_xfer_bytes))
        else $error("residual not data length minus transferred");
    a_cpl_holds: assert property (
        cpl_valid_r && !cpl_ready |=> cpl_valid_r && $stable(cpl_status_r))
        else $error("completion dropped before accepted");
    a_ready_returns: assert property (
        cpl_valid_r && cpl_ready |=> ##[0:1] req_ready_r)
        else $error("ready not restored after completion");

    c_read_ok:   cover property (state_r == BRP_ST_WAIT && mem_done && op_r == BRP_OP_READ);
    c_ro_write:  cover property (cpl_valid_r && op_r == BRP_OP_WRITE && feat_ro);
    c_flush:     cover property (mem_valid_r && mem_ready && op_r == BRP_OP_FLUSH);
    c_scsi:      cover property (cpl_valid_r && op_r == BRP_OP_SCSI);
    c_unsupp:    cover property (cpl_valid_r && cpl_status_r == STAT_UNSUPP);

endmodule

// ==== src/brp_scsi_result.sv ====
`timescale 1ns/1ps
module brp_scsi_result
    import brp_pkg::*;
(
    input  wire logic [31:0] data_bytes,
    input  wire logic [31:0] xfer_bytes,
    input  wire logic [31:0] sense_bytes,
    output logic [31:0]      sense_len,
    output logic [31:0]      residual
);

    // ----------------------------------------------------------------
    // sense length clamp and residual
    // ----------------------------------------------------------------
    always_comb begin
        sense_len = (sense_bytes > SENSE_BYTES) ? SENSE_BYTES : sense_bytes;
        residual  = (xfer_bytes > data_bytes) ? '0 : (data_bytes - xfer_bytes);
    end

endmodule
